// *** dma_chan_pkg.sv ***
// Shared constants and state types of the DMA channel address and count block
package dma_chan_pkg;
   localparam int AXI_AW = 12;
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 8;
   localparam logic [11:0] OFS_CONFIG = 12'h044;
   localparam logic [11:0] OFS_COUNT = 12'h048;
   localparam logic [11:0] OFS_PERIPH = 12'h04C;
   localparam logic [11:0] OFS_MEM = 12'h050;
   localparam int CFG_EN = 0;
   localparam int CFG_DIR = 4;
   localparam int CFG_CYCLIC = 5;
   localparam int CFG_PINC = 6;
   localparam int CFG_MINC = 7;
   localparam int CFG_PW_LSB = 8;
   localparam int CFG_MW_LSB = 10;
   localparam logic [31:0] CFG_MASK = 32'h0000_0FF1;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [15:0] RESET_COUNT = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [1:0] WIDTH_BYTE = 2'b00;
   localparam logic [1:0] WIDTH_HALF = 2'b01;
   localparam logic [1:0] WIDTH_WORD = 2'b10;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [31:0] addr;
      logic [1:0] width;
   } xfer_req_t;

   typedef struct packed {
      logic [31:0] cfg;
      logic [31:0] periph;
      logic [31:0] mem;
      logic [15:0] count;
      logic [15:0] reload;
      logic [15:0] readsLeft;
      logic [31:0] srcPtr;
      logic [31:0] dstPtr;
      logic awHeld;
      logic wHeld;
      logic [11:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [1:0] rResp;
      logic [31:0] rData;
   } chan_t;
endpackage

// *** dma_channel_address_count.sv ***
// Data FIFO and the DMA channel with its address pointers and transfer counter
`timescale 1ns/100ps
`default_nettype none

module fifo_buffer #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic flush,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } fifo_t;
   fifo_t s_q;
   fifo_t s_d;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign inReady = (s_q.cnt != (PW+1)'(DEPTH)) && !flush;
   assign outValid = (s_q.cnt != '0) && !flush;
   assign outData = s_q.mem[s_q.rp];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb
   begin
      s_d = s_q;
      if (flush)
      begin
         s_d.wp = '0;
         s_d.rp = '0;
         s_d.cnt = '0;
      end
      else
      begin
         if (push)
         begin
            s_d.mem[s_q.wp] = inData;
            s_d.wp = bump(s_q.wp);
         end
         if (pop)
         begin
            s_d.rp = bump(s_q.rp);
         end
         s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule // fifo_buffer

module dma_channel_address_count
   import dma_chan_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic awvalid,
   output logic awready,
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [AXI_AW-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rdValid,
   input wire logic rdReady,
   output xfer_req_t rdReq,
   input wire logic rspValid,
   output logic rspReady,
   input wire logic [DATA_W-1:0] rspData,
   output logic wrValid,
   input wire logic wrReady,
   output xfer_req_t wrReq,
   output logic [DATA_W-1:0] wrData
);
   chan_t s_q;
   chan_t s_d;
   logic en;
   logic dir;
   logic cyc;
   logic [1:0] pw;
   logic [1:0] mw;
   logic [1:0] srcW;
   logic [1:0] dstW;
   logic srcInc;
   logic dstInc;
   logic fifoValid;
   logic regWrite;
   logic rdHs;
   logic wrHs;
   logic [31:0] wordIn;

   function automatic logic [31:0] alignAddr(input logic [31:0] a, input logic [1:0] w);
      // Reserved width code falls back to byte access
      if (w == WIDTH_WORD)
         alignAddr = {a[31:2], 2'b00};
      else if (w == WIDTH_HALF)
         alignAddr = {a[31:1], 1'b0};
      else
         alignAddr = a;
   endfunction

   function automatic logic [31:0] stepOf(input logic [1:0] w);
      if (w == WIDTH_WORD)
         stepOf = 32'h0000_0004;
      else if (w == WIDTH_HALF)
         stepOf = 32'h0000_0002;
      else
         stepOf = 32'h0000_0001;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
      merge = old;
      for (int i = 0; i < 4; i++)
      begin
         if (st[i])
            merge[8*i +: 8] = d[8*i +: 8];
      end
   endfunction

   assign en = s_q.cfg[CFG_EN];
   assign dir = s_q.cfg[CFG_DIR];
   assign cyc = s_q.cfg[CFG_CYCLIC];
   assign pw = s_q.cfg[CFG_PW_LSB +: 2];
   assign mw = s_q.cfg[CFG_MW_LSB +: 2];
   assign srcW = dir ? mw : pw;
   assign dstW = dir ? pw : mw;
   assign srcInc = dir ? s_q.cfg[CFG_MINC] : s_q.cfg[CFG_PINC];
   assign dstInc = dir ? s_q.cfg[CFG_PINC] : s_q.cfg[CFG_MINC];

   assign awready = !s_q.awHeld && !s_q.bValid;
   assign wready = !s_q.wHeld && !s_q.bValid;
   assign bvalid = s_q.bValid;
   assign bresp = s_q.bResp;
   assign arready = !s_q.rValid;
   assign rvalid = s_q.rValid;
   assign rdata = s_q.rData;
   assign rresp = s_q.rResp;
   assign regWrite = s_q.awHeld && s_q.wHeld && !s_q.bValid;
   assign wordIn = merge(RESET_WORD, s_q.wData, s_q.wStrb);

   assign rdValid = en && (s_q.readsLeft != RESET_COUNT);
   assign wrValid = en && fifoValid && (s_q.count != RESET_COUNT);
   assign rdReq.addr = alignAddr(s_q.srcPtr, srcW);
   assign rdReq.width = srcW;
   assign wrReq.addr = alignAddr(s_q.dstPtr, dstW);
   assign wrReq.width = dstW;
   assign rdHs = rdValid && rdReady;
   assign wrHs = wrValid && wrReady;

   // Flush on disable so words left in the FIFO never reach a new block
   fifo_buffer #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) fifo_buffer_inst (
      .clock(clock),
      .rst(rst),
      .flush(!en),
      .inValid(rspValid),
      .inReady(rspReady),
      .inData(rspData),
      .outValid(fifoValid),
      .outReady(wrReady && en && (s_q.count != RESET_COUNT)),
      .outData(wrData)
   );

   always_comb
   begin
      s_d = s_q;
      if (en)
      begin
         if (rdHs)
         begin
            if (s_q.readsLeft == COUNT_ONE && cyc)
            begin
               s_d.readsLeft = s_q.reload;
               s_d.srcPtr = dir ? s_q.mem : s_q.periph;
            end
            else
            begin
               s_d.readsLeft = s_q.readsLeft - COUNT_ONE;
               if (srcInc)
                  s_d.srcPtr = s_q.srcPtr + stepOf(srcW);
            end
         end
         if (wrHs)
         begin
            if (s_q.count == COUNT_ONE)
            begin
               if (cyc)
               begin
                  s_d.count = s_q.reload;
                  s_d.dstPtr = dir ? s_q.periph : s_q.mem;
               end
               else
                  s_d.count = RESET_COUNT;
            end
            else
            begin
               s_d.count = s_q.count - COUNT_ONE;
               if (dstInc)
                  s_d.dstPtr = s_q.dstPtr + stepOf(dstW);
            end
         end
      end
      if (awvalid && awready)
      begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = awaddr;
      end
      if (wvalid && wready)
      begin
         s_d.wHeld = 1'b1;
         s_d.wData = wdata;
         s_d.wStrb = wstrb;
      end
      if (s_q.bValid && bready)
         s_d.bValid = 1'b0;
      if (regWrite)
      begin
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp = RESP_OKAY;
         if (s_q.awAddr == OFS_CONFIG)
            s_d.cfg = merge(s_q.cfg, s_q.wData, s_q.wStrb) & CFG_MASK;
         else if (s_q.awAddr == OFS_COUNT)
         begin
            if (!en)
            begin
               s_d.count = wordIn[15:0];
               s_d.reload = wordIn[15:0];
            end
         end
         else if (s_q.awAddr == OFS_PERIPH)
            s_d.periph = merge(s_q.periph, s_q.wData, s_q.wStrb);
         else if (s_q.awAddr == OFS_MEM)
            s_d.mem = merge(s_q.mem, s_q.wData, s_q.wStrb);
         else
            s_d.bResp = RESP_SLVERR;
      end
      if (s_q.rValid && rready)
         s_d.rValid = 1'b0;
      if (arvalid && arready)
      begin
         s_d.rValid = 1'b1;
         s_d.rResp = RESP_OKAY;
         if (araddr == OFS_CONFIG)
            s_d.rData = s_q.cfg;
         else if (araddr == OFS_COUNT)
            s_d.rData = {16'h0000, s_q.count};
         else if (araddr == OFS_PERIPH)
            s_d.rData = s_q.periph;
         else if (araddr == OFS_MEM)
            s_d.rData = s_q.mem;
         else
         begin
            s_d.rData = RESET_WORD;
            s_d.rResp = RESP_SLVERR;
         end
      end
      // idle pointers track the next bases and direction
      if (!en)
      begin
         s_d.readsLeft = s_d.count;
         s_d.srcPtr = s_d.cfg[CFG_DIR] ? s_d.mem : s_d.periph;
         s_d.dstPtr = s_d.cfg[CFG_DIR] ? s_d.periph : s_d.mem;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   end_zero_a: assert property (wrHs && s_q.count == COUNT_ONE && !cyc |=> s_q.count == RESET_COUNT)
      else $error("count not zero after block end");
   cyclic_reload_a: assert property (wrHs && s_q.count == COUNT_ONE && cyc
      |=> s_q.count == $past(s_q.reload))
      else $error("count not reloaded in cyclic mode");
   zero_count_idle_a: assert property (en && s_q.count == RESET_COUNT |-> !wrValid && !rdValid)
      else $error("transfer with zero count");
   periph_base_a: assert property ($rose(en) && !dir
      |-> rdReq.addr == alignAddr($past(s_q.periph), pw))
      else $error("peripheral base not used");
   periph_half_a: assert property (rdValid && !dir && pw == WIDTH_HALF |-> rdReq.addr[0] == 1'b0)
      else $error("peripheral half-word misaligned");
   periph_word_a: assert property (wrValid && dir && pw == WIDTH_WORD |-> wrReq.addr[1:0] == 2'b00)
      else $error("peripheral word misaligned");
   mem_base_a: assert property ($rose(en) && !dir
      |-> wrReq.addr == alignAddr($past(s_q.mem), mw))
      else $error("memory base not used");
   mem_half_a: assert property (rdValid && dir && mw == WIDTH_HALF |-> rdReq.addr[0] == 1'b0)
      else $error("memory half-word misaligned");
   mem_word_a: assert property (wrValid && !dir && mw == WIDTH_WORD |-> wrReq.addr[1:0] == 2'b00)
      else $error("memory word misaligned");
   count_step_a: assert property (wrHs && s_q.count > COUNT_ONE
      |=> s_q.count == $past(s_q.count) - COUNT_ONE)
      else $error("count did not step by one");
   bases_held_a: assert property (en && !regWrite |=> $stable(s_q.periph) && $stable(s_q.mem))
      else $error("programmed address moved");

   cover property (wrHs && s_q.count == COUNT_ONE && cyc);
   cover property (wrHs && s_q.count == COUNT_ONE && !cyc);
   cover property (en && !rspReady);
endmodule // dma_channel_address_count

`default_nettype wire

// *** dma_far_model.sv ***
// Peripheral and memory slaves at the far side of the DMA channel
`timescale 1ns/100ps
`default_nettype none
module dma_far_model
   import dma_chan_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic slow,
   input wire logic hold,
   input wire logic rdValid,
   output logic rdReady,
   input wire xfer_req_t rdReq,
   output logic rspValid,
   input wire logic rspReady,
   output logic [31:0] rspData,
   input wire logic wrValid,
   output logic wrReady,
   input wire xfer_req_t wrReq,
   input wire logic [31:0] wrData,
   output logic [31:0] lastData,
   output logic [31:0] lastRd,
   output logic [31:0] lastWr,
   output logic [31:0] nWrites
);
   logic [31:0] pend[$];
   logic [3:0] tick;
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pend.delete();
         tick <= 4'h0;
         rspValid <= 1'b0;
         rspData <= 32'h0000_0000;
         rdReady <= 1'b0;
         wrReady <= 1'b0;
         lastRd <= 32'h0000_0000;
         lastWr <= 32'h0000_0000;
         lastData <= 32'h0000_0000;
         nWrites <= 32'h0000_0000;
      end
      else
      begin
         tick <= tick + 4'h1;
         // Slow mode stalls both links now and then
         rdReady <= !(slow && tick[1]);
         wrReady <= !hold && !(slow && tick[2]);
         if (rdValid && rdReady)
         begin
            pend.push_back({rdReq.addr[15:0], 16'hA5C3});
            lastRd <= rdReq.addr;
         end
         // Idle data line shows the inverse, never the last word
         if (rspValid && rspReady)
         begin
            rspValid <= 1'b0;
            rspData <= ~rspData;
         end
         else if (!rspValid && pend.size() > 0 && !(slow && tick[0]))
         begin
            rspValid <= 1'b1;
            rspData <= pend.pop_front();
         end
         if (wrValid && wrReady)
         begin
            lastWr <= wrReq.addr;
            lastData <= wrData;
            nWrites <= nWrites + 32'h1;
         end
      end
   end
endmodule // dma_far_model
`default_nettype wire

// *** test_dma_channel_address_count.sv ***
// Self-checking testbench of the DMA channel address and count block
`timescale 1ns/100ps
`default_nettype none
module test_dma_channel_address_count
   import dma_chan_pkg::*;
;
   logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, rdValid, rdReady, rspValid, rspReady;
   logic wrValid, wrReady, slow, hold;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rspData, wrData, lastRd, lastWr, nWrites, rd, base, lastData;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   xfer_req_t rdReq, wrReq;
   int nFail = 0;
   int checksDone = 0;

   dma_channel_address_count dma_channel_address_count_inst (.clock(clock), .rst(rst),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .rdValid(rdValid),
      .rdReady(rdReady), .rdReq(rdReq), .rspValid(rspValid), .rspReady(rspReady),
      .rspData(rspData), .wrValid(wrValid), .wrReady(wrReady), .wrReq(wrReq),
      .wrData(wrData));
   dma_far_model dma_far_model_inst (.clock(clock), .rst(rst), .slow(slow), .hold(hold),
      .rdValid(rdValid), .rdReady(rdReady), .rdReq(rdReq), .rspValid(rspValid),
      .rspReady(rspReady), .rspData(rspData), .wrValid(wrValid), .wrReady(wrReady),
      .wrReq(wrReq), .wrData(wrData), .lastData(lastData), .lastRd(lastRd), .lastWr(lastWr),
      .nWrites(nWrites));

   always #5 clock = ~clock;

   task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp)
      begin
         nFail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      rs = bresp;
   endtask

   task automatic axiRead(input logic [11:0] a);
      @(posedge clock);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd = rdata;
      rs = rresp;
   endtask

   // Polls the live count; bounded so a stuck channel cannot hang here
   task automatic waitDone();
      int k;
      k = 0;
      do
      begin
         axiRead(OFS_COUNT);
         k++;
      end while (rd[15:0] !== 16'h0000 && k < 400);
   endtask

   task automatic setup(input logic [31:0] cnt, input logic [31:0] cfg);
      axiWrite(OFS_CONFIG, 32'h0000_0000);
      axiWrite(OFS_COUNT, cnt);
      axiWrite(OFS_CONFIG, cfg);
   endtask

   task automatic finalReport();
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      #200000;
      nFail++;
      finalReport();
   end

   initial
   begin
      clock = 0;
      rst = 1;
      {awvalid, wvalid, bready, arvalid, rready, hold} = 6'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      slow = 1;
      repeat (10) @(posedge clock);
      rst <= 0;
      axiRead(OFS_PERIPH);
      check32("periph reset", 32'h0000_0000, rd);
      axiRead(OFS_MEM);
      check32("mem reset", 32'h0000_0000, rd);
      axiRead(12'h0F0);
      check32("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      axiWrite(12'h0F0, 32'h1234_5678);
      check32("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      $display("test registers done");
      // Half-word periph source, word memory dest; FIFO fills while dest stalls
      axiWrite(OFS_PERIPH, 32'h4000_1003);
      axiWrite(OFS_MEM, 32'h2000_0107);
      hold <= 1;
      setup(32'h0000_000C, 32'h0000_0981);
      repeat (40) @(posedge clock);
      check32("fifo full refuses", 32'h0, {31'h0, rspReady});
      hold <= 0;
      waitDone();
      check32("count after block", 32'h0000_0000, rd);
      check32("writes in block", 32'h0000_000C, nWrites);
      check32("periph read addr", 32'h4000_1002, lastRd);
      check32("mem write addr", 32'h2000_0130, lastWr);
      check32("data written", 32'h1002_A5C3, lastData);
      axiRead(OFS_PERIPH);
      check32("periph kept", 32'h4000_1003, rd);
      axiRead(OFS_MEM);
      check32("mem kept", 32'h2000_0107, rd);
      $display("test periph to mem done");
      // Memory source half-word fixed, word periph dest stepping by four
      setup(32'h0000_0002, 32'h0000_0651);
      waitDone();
      check32("writes reverse", 32'h0000_000E, nWrites);
      check32("mem read addr", 32'h2000_0106, lastRd);
      check32("periph write addr", 32'h4000_1004, lastWr);
      check32("data reverse", 32'h0106_A5C3, lastData);
      $display("test mem to periph done");
      base = nWrites;
      setup(32'h0000_0000, 32'h0000_0001);
      repeat (30) @(posedge clock);
      check32("zero count idle", base, nWrites);
      check32("zero count no request", 32'h0, {31'h0, rdValid});
      $display("test zero count done");
      setup(32'h0000_0002, 32'h0000_0021);
      repeat (300) @(posedge clock);
      check32("cyclic keeps going", 32'h1, {31'h0, nWrites >= base + 32'h6});
      axiWrite(OFS_CONFIG, 32'h0000_0000);
      axiRead(OFS_COUNT);
      check32("cyclic reload", 32'h1, {31'h0, (rd[15:0] inside {16'h0001, 16'h0002})});
      $display("test cyclic done");
      finalReport();
   end
endmodule // test_dma_channel_address_count
`default_nettype wire
